// >>> src/epm_pkg.sv
// package for the external program memory bus: modes, widths, timing
package epm_pkg;
  // bus interface modes
  typedef enum logic [1:0] {
    EPM_BUS16,
    EPM_BUS8_MUX,
    EPM_BUS8_DEMUX
  } epm_bus_mode_type;
  // table write mode field encodings (16-bit bus only)
  localparam logic [1:0] EPM_WM_BYTE_WRITE = 2'h0;
  localparam logic [1:0] EPM_WM_BYTE_SELECT = 2'h1;
  localparam int EPM_WM_WORD_BIT = 1;
  // widths
  localparam int EPM_PTR_W = 21;
  localparam int EPM_ADDR_W = 20;
  localparam int EPM_MUX_ADDR_BITS = 17;
  localparam int EPM_DATA_W = 16;
  localparam int EPM_BYTE_W = 8;
  localparam int EPM_PTR_LSB = 0;
  // reset values
  localparam logic [7:0] EPM_BYTE_ZERO = 8'h00;
  localparam logic [15:0] EPM_WORD_ZERO = 16'h0000;
  localparam logic [19:0] EPM_ADDR_ZERO = 20'h0_0000;
  // bus phase lengths in cycles of the 125 MHz clock
  // four cycles: the pin synchroniser adds two before read data is seen
  localparam int EPM_CLK_PERIOD_NS = 8;
  localparam int EPM_PHASE_NS = 32;
  localparam int EPM_PHASE_CYC = (EPM_PHASE_NS + EPM_CLK_PERIOD_NS - 1) / EPM_CLK_PERIOD_NS;
  localparam logic [3:0] EPM_PHASE_LAST = 4'(EPM_PHASE_CYC - 1);
endpackage : epm_pkg

// >>> src/epm_lane_if.sv
// interface carrying the write lane steering between the sequencer and the lane unit
`timescale 1ns/1ps
interface epm_lane_if;
  import epm_pkg::*;
  logic [1:0] wm;
  epm_bus_mode_type mode;
  logic ptr_lsb;
  logic [7:0] wdata;
  logic capture;
  logic [15:0] out_word;
  logic drive_data;
  logic strobe_high;
  logic strobe_low;
  logic [7:0] hold_byte;
  modport seq (output wm, mode, ptr_lsb, wdata, capture,
               input out_word, drive_data, strobe_high, strobe_low, hold_byte);
  modport lane (input wm, mode, ptr_lsb, wdata, capture,
                output out_word, drive_data, strobe_high, strobe_low, hold_byte);
endinterface : epm_lane_if

// >>> src/epm_lane.sv
// write lane steering and the word-write holding register
`timescale 1ns/1ps
module epm_lane (
  // clocking
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clk_en,
  // steering
  epm_lane_if.lane lif
);
  import epm_pkg::*;

  logic [7:0] hold_reg;
  logic is_16;
  logic word_mode;

  // mode decode shared by the steering terms
  assign is_16 = (lif.mode == EPM_BUS16);
  assign word_mode = lif.wm[EPM_WM_WORD_BIT];

  // holding register keeps its byte until the next even word-write
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      hold_reg <= EPM_BYTE_ZERO;
    end else if (clk_en && lif.capture && is_16 && word_mode && !lif.ptr_lsb) begin
      hold_reg <= lif.wdata;
    end
  end
  assign lif.hold_byte = hold_reg;

  // lane and strobe selection
  always_comb begin
    lif.out_word = {lif.wdata, lif.wdata};
    lif.drive_data = 1'b1;
    lif.strobe_high = 1'b0;
    lif.strobe_low = 1'b0;
    if (!is_16) begin
      lif.out_word = {EPM_BYTE_ZERO, lif.wdata};
      lif.strobe_low = 1'b1;
    end else if (word_mode) begin
      if (lif.ptr_lsb) begin
        lif.out_word = {lif.wdata, hold_reg};
        lif.strobe_high = 1'b1;
      end else begin
        lif.drive_data = 1'b0;
      end
    end else if (lif.wm == EPM_WM_BYTE_SELECT) begin
      lif.strobe_high = 1'b1;
    end else begin
      lif.strobe_high = lif.ptr_lsb;
      lif.strobe_low = !lif.ptr_lsb;
    end
  end

  // even word-write never fires a strobe
  a_even_no_strobe: assert property (@(posedge clock) disable iff (sys_rst)
    (is_16 && word_mode && !lif.ptr_lsb) |-> !lif.strobe_high && !lif.strobe_low)
    else $error("even word write fired a strobe");
endmodule : epm_lane

// >>> src/epm_bus.sv
// external program memory bus sequencer: fetch, table read and table write cycles
// What this block does
// - byte-select write: high strobe, byte on both lanes
// - byte-select: byte address or enables follow pointer
// - word-write even: hold byte, float data, no strobe
// - word-write odd: new byte high, held byte low
// - word-write pulses only high strobe
// - word-write asserts both byte enables
// - 8-bit mux: address latch separates address, data
// - 8-bit fetch: two bytes, byte address toggles
// - 8-bit mux: 18-bit byte address
// - 8-bit: high strobe, byte enables become port
// - 8-bit: low strobe on every write
// - 8-bit demux: address stable whole fetch
// - 8-bit demux: 21-bit byte address
// - 8-bit: one byte per table operation
// - 8-bit peripheral write: upper lane is dummy
// - write mode field picks 16-bit write mode
// - pointer bit 0 to byte address, rest to address (only bits 17:1 in 8-bit mux)
// - 16-bit table read picks lane by lsb
// - byte-write: both lanes, strobe by lsb
`timescale 1ns/1ps
module epm_bus (
  // clocking
  clock,
  sys_rst,
  clk_en,
  // configuration
  bus_mode,
  table_write_mode_field,
  // cpu request side
  req_valid,
  req_kind,
  table_address_pointer,
  table_data_latch,
  busy,
  done,
  rd_data,
  instr_word,
  // external bus pins
  addr_latch_strobe,
  output_enable_n,
  write_strobe_low_n,
  write_strobe_high_n,
  byte_address_lsb,
  upper_byte_enable_n,
  lower_byte_enable_n,
  addr_out,
  data_out,
  data_oe_n,
  data_in,
  port_mode
);
  import epm_pkg::*;
  input wire logic clock;
  input wire logic sys_rst;
  input wire logic clk_en;
  input wire epm_pkg::epm_bus_mode_type bus_mode;
  input wire logic [1:0] table_write_mode_field;
  input wire logic req_valid;
  input wire logic [1:0] req_kind; // 0 fetch, 1 table_read_op, 2 table write
  input wire logic [epm_pkg::EPM_PTR_W-1:0] table_address_pointer;
  input wire logic [7:0] table_data_latch;
  output logic busy;
  output logic done;
  output logic [7:0] rd_data;
  output logic [15:0] instr_word;
  output logic addr_latch_strobe;
  output logic output_enable_n;
  output logic write_strobe_low_n;
  output logic write_strobe_high_n;
  output logic byte_address_lsb;
  output logic upper_byte_enable_n;
  output logic lower_byte_enable_n;
  output logic [epm_pkg::EPM_ADDR_W-1:0] addr_out;
  output logic [15:0] data_out;
  output logic data_oe_n;
  input wire logic [15:0] data_in;
  output logic port_mode;

  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_DATA, ST_DATA2, ST_DONE} epm_state_type;
  localparam logic [1:0] KIND_FETCH = 2'h0;
  localparam logic [1:0] KIND_READ = 2'h1;
  localparam logic [1:0] KIND_WRITE = 2'h2;

  epm_state_type state_reg;
  logic [3:0] cnt_reg;
  logic [1:0] kind_reg;
  logic [EPM_PTR_W-1:0] ptr_reg;
  logic [7:0] wbyte_reg;
  logic [15:0] din_s1_reg;
  logic [15:0] din_s2_reg;
  logic phase_end;
  logic is_8;
  epm_lane_if lif();

  // picks the addressed byte from a 16-bit word by pointer lsb
  function automatic logic [7:0] epm_pick_byte(input logic [15:0] w, input logic lsb);
    epm_pick_byte = lsb ? w[15:8] : w[7:0];
  endfunction : epm_pick_byte

  assign is_8 = (bus_mode != EPM_BUS16);
  assign phase_end = (cnt_reg == EPM_PHASE_LAST);

  // lane steering unit
  assign lif.wm = table_write_mode_field;
  assign lif.mode = bus_mode;
  assign lif.ptr_lsb = ptr_reg[EPM_PTR_LSB];
  assign lif.wdata = wbyte_reg;
  assign lif.capture = (state_reg == ST_DATA) && phase_end && (kind_reg == KIND_WRITE);
  epm_lane u_lane (
    .clock(clock),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .lif(lif.lane)
  );

  // two-flop synchroniser on the external data pins
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      din_s1_reg <= EPM_WORD_ZERO;
      din_s2_reg <= EPM_WORD_ZERO;
    end else if (clk_en) begin
      din_s1_reg <= data_in;
      din_s2_reg <= din_s1_reg;
    end
  end

  // sequencer: address phase, one or two data phases
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
      cnt_reg <= '0;
      kind_reg <= KIND_FETCH;
      ptr_reg <= '0;
      wbyte_reg <= EPM_BYTE_ZERO;
    end else if (clk_en) begin
      cnt_reg <= phase_end ? '0 : cnt_reg + 4'h1;
      case (state_reg)
        ST_IDLE: begin
          cnt_reg <= '0;
          if (req_valid) begin
            kind_reg <= req_kind;
            ptr_reg <= table_address_pointer;
            wbyte_reg <= table_data_latch;
            state_reg <= ST_ADDR;
          end
        end
        ST_ADDR: if (phase_end) begin
          state_reg <= ST_DATA;
        end
        ST_DATA: if (phase_end) begin
          // only an 8-bit fetch needs a second byte
          if (is_8 && kind_reg == KIND_FETCH) begin
            state_reg <= ST_DATA2;
            ptr_reg[EPM_PTR_LSB] <= 1'b1;
          end else begin
            state_reg <= ST_DONE;
          end
        end
        ST_DATA2: if (phase_end) begin
          state_reg <= ST_DONE;
        end
        ST_DONE: state_reg <= ST_IDLE;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // read data capture; data sampled from synchronised pins at phase end
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rd_data <= EPM_BYTE_ZERO;
      instr_word <= EPM_WORD_ZERO;
    end else if (clk_en && phase_end) begin
      if (state_reg == ST_DATA && kind_reg == KIND_READ) begin
        rd_data <= is_8 ? din_s2_reg[7:0] : epm_pick_byte(din_s2_reg, ptr_reg[EPM_PTR_LSB]);
      end
      if (state_reg == ST_DATA && kind_reg == KIND_FETCH) begin
        instr_word <= is_8 ? {instr_word[15:8], din_s2_reg[7:0]} : din_s2_reg;
      end
      if (state_reg == ST_DATA2) begin
        instr_word <= {din_s2_reg[7:0], instr_word[7:0]};
      end
    end
  end

  // pin drive registered from state; a fetch always reads even byte first
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      busy <= 1'b0;
      done <= 1'b0;
      addr_latch_strobe <= 1'b0;
      output_enable_n <= 1'b1;
      write_strobe_low_n <= 1'b1;
      write_strobe_high_n <= 1'b1;
      byte_address_lsb <= 1'b0;
      upper_byte_enable_n <= 1'b1;
      lower_byte_enable_n <= 1'b1;
      addr_out <= EPM_ADDR_ZERO;
      data_out <= EPM_WORD_ZERO;
      data_oe_n <= 1'b1;
      port_mode <= 1'b0;
    end else if (clk_en) begin
      busy <= (state_reg != ST_IDLE) && (state_reg != ST_DONE);
      done <= (state_reg == ST_DONE);
      port_mode <= is_8;
      addr_latch_strobe <= (state_reg == ST_ADDR) && (bus_mode != EPM_BUS8_DEMUX);
      // byte address from pointer bit 0 (low for a fetch's first byte), upper pointer bits held all cycle
      byte_address_lsb <= (kind_reg == KIND_FETCH && state_reg != ST_DATA2) ? 1'b0 : ptr_reg[EPM_PTR_LSB];
      if (bus_mode == EPM_BUS8_MUX) begin
        addr_out <= {3'h0, ptr_reg[EPM_MUX_ADDR_BITS:1]};
      end else begin
        addr_out <= ptr_reg[EPM_PTR_W-1:1];
      end
      output_enable_n <= !((state_reg == ST_DATA || state_reg == ST_DATA2) && kind_reg != KIND_WRITE);
      // outside the demux mode the address byte shares the low data pins
      if (state_reg == ST_ADDR && bus_mode != EPM_BUS8_DEMUX) begin
        data_out <= {8'h00, ptr_reg[8:1]};
        data_oe_n <= 1'b0;
      end else if (state_reg == ST_DATA && kind_reg == KIND_WRITE) begin
        data_out <= lif.out_word;
        data_oe_n <= !lif.drive_data;
      end else begin
        data_oe_n <= 1'b1;
      end
      write_strobe_high_n <= !(state_reg == ST_DATA && kind_reg == KIND_WRITE && lif.strobe_high && !is_8);
      write_strobe_low_n <= !(state_reg == ST_DATA && kind_reg == KIND_WRITE && lif.strobe_low);
      if (is_8) begin
        upper_byte_enable_n <= 1'b1;
        lower_byte_enable_n <= 1'b1;
      end else if (kind_reg == KIND_WRITE && table_write_mode_field[EPM_WM_WORD_BIT]) begin
        upper_byte_enable_n <= 1'b0;
        lower_byte_enable_n <= 1'b0;
      end else if (kind_reg == KIND_WRITE && table_write_mode_field == EPM_WM_BYTE_SELECT) begin
        upper_byte_enable_n <= !ptr_reg[EPM_PTR_LSB];
        lower_byte_enable_n <= ptr_reg[EPM_PTR_LSB];
      end else begin
        upper_byte_enable_n <= 1'b0;
        lower_byte_enable_n <= 1'b0;
      end
    end
  end

  // assertions
  sequence s_write_data;
    state_reg == ST_DATA && kind_reg == KIND_WRITE;
  endsequence

  a_sel_high_only: assert property (@(posedge clock) disable iff (sys_rst || !clk_en)
    (s_write_data and (!is_8 && table_write_mode_field == EPM_WM_BYTE_SELECT)) |=> !write_strobe_high_n && write_strobe_low_n)
    else $error("byte select write strobe wrong");
  a_sel_lane_copy: assert property (@(posedge clock) disable iff (sys_rst || !clk_en)
    (s_write_data and (!is_8 && table_write_mode_field == EPM_WM_BYTE_SELECT)) |=> data_out[15:8] == data_out[7:0])
    else $error("byte select lanes differ");
  a_word_odd_lanes: assert property (@(posedge clock) disable iff (sys_rst || !clk_en)
    (s_write_data and (!is_8 && table_write_mode_field[1] && ptr_reg[0])) |=> data_out == {$past(wbyte_reg), $past(lif.hold_byte)} && !data_oe_n)
    else $error("word write odd lanes wrong");
  a_word_even_float: assert property (@(posedge clock) disable iff (sys_rst || !clk_en)
    (s_write_data and (!is_8 && table_write_mode_field[1] && !ptr_reg[0])) |=> data_oe_n && write_strobe_high_n && write_strobe_low_n)
    else $error("word write even drove bus");
  a_word_enables: assert property (@(posedge clock) disable iff (sys_rst || !clk_en)
    (s_write_data and (!is_8 && table_write_mode_field[1])) |=> !upper_byte_enable_n && !lower_byte_enable_n && write_strobe_low_n)
    else $error("word write enables wrong");
  a_eight_low_strobe: assert property (@(posedge clock) disable iff (sys_rst || !clk_en)
    (s_write_data and is_8) |=> !write_strobe_low_n && write_strobe_high_n && upper_byte_enable_n)
    else $error("8-bit write strobe wrong");
  a_fetch_two_bytes: assert property (@(posedge clock) disable iff (sys_rst || !clk_en)
    (state_reg == ST_DATA && phase_end && is_8 && kind_reg == KIND_FETCH) |=> state_reg == ST_DATA2 ##1 byte_address_lsb)
    else $error("8-bit fetch missed second byte");
  a_read_lane_pick: assert property (@(posedge clock) disable iff (sys_rst || !clk_en)
    (state_reg == ST_DATA && phase_end && kind_reg == KIND_READ && !is_8) |=> rd_data == epm_pick_byte($past(din_s2_reg), ptr_reg[0]))
    else $error("table read lane wrong");
  a_addr_stable: assert property (@(posedge clock) disable iff (sys_rst || !clk_en)
    (state_reg == ST_DATA && bus_mode == EPM_BUS8_DEMUX) |=> $stable(addr_out))
    else $error("address moved during fetch");
endmodule : epm_bus

// >>> testbench/epm_mem_model.sv
// behavioural external memory that answers read cycles on the bus pins
`timescale 1ns/1ps
module epm_mem_model (
  // bus pins
  input wire logic clock,
  input wire logic output_enable_n,
  input wire logic byte_address_lsb,
  input wire logic [19:0] addr_out,
  input wire logic bus16,
  // data back to the device
  output logic [15:0] data_in
);
  logic [15:0] junk_reg = 16'h5a5a;
  // byte content is a fixed function of the full byte address
  function automatic logic [7:0] mem_byte(input logic [20:0] a);
    return a[7:0] ^ a[15:8] ^ {a[20:16], 3'h5};
  endfunction : mem_byte
  // a released bus shows a changing pattern, never the last value
  always_ff @(posedge clock) begin
    junk_reg <= ~junk_reg + 16'h0001;
  end
  // memory A0 comes from the byte address output in 8-bit wiring
  assign data_in = output_enable_n ? junk_reg : bus16 ?
    {mem_byte({addr_out, 1'b1}), mem_byte({addr_out, 1'b0})} :
    {junk_reg[15:8], mem_byte({addr_out, byte_address_lsb})};
endmodule : epm_mem_model

// >>> testbench/epm_bus_tb.sv
// self-checking bench for the external program memory bus sequencer
`timescale 1ns/1ps
module epm_bus_tb;
  import epm_pkg::*;
  logic clock, sys_rst, clk_en, req_valid, busy, done;
  epm_bus_mode_type bus_mode;
  logic [1:0] table_write_mode_field, req_kind;
  logic [20:0] table_address_pointer, p;
  logic [7:0] table_data_latch, rd_data, held;
  logic [15:0] instr_word, data_out, data_in, wdat;
  logic [19:0] addr_out, a0;
  logic addr_latch_strobe, output_enable_n, write_strobe_low_n, write_strobe_high_n;
  logic byte_address_lsb, upper_byte_enable_n, lower_byte_enable_n, data_oe_n, port_mode;
  logic act, s_wh, s_wl, s_ub, s_lb, s_ale, s_ba0, s_ba1, s_mov, s_ba;
  logic [31:0] rnd;
  int fail_count, checked;
  // ----------------------------------------
  // design, far-side memory and clock
  // ----------------------------------------
  epm_bus epm_bus_inst (.*);
  epm_mem_model epm_mem_model_inst (.clock(clock), .output_enable_n(output_enable_n),
    .byte_address_lsb(byte_address_lsb), .addr_out(addr_out),
    .bus16(bus_mode == EPM_BUS16), .data_in(data_in));
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // gather what the pins did over one bus cycle
  always @(posedge clock) begin
    if (act) begin
      s_ale <= s_ale | addr_latch_strobe;
      // enables only count while the cycle runs; idle pins keep the last kind
      if (busy) begin
        s_ub <= s_ub | !upper_byte_enable_n;
        s_lb <= s_lb | !lower_byte_enable_n;
      end
      s_wh <= s_wh | !write_strobe_high_n;
      s_wl <= s_wl | !write_strobe_low_n;
      // address must hold whenever a strobe or read enable is active
      if (!output_enable_n || !write_strobe_low_n || !write_strobe_high_n) begin
        s_mov <= s_mov | (addr_out !== a0);
      end
      if (!output_enable_n) begin
        s_ba0 <= s_ba0 | !byte_address_lsb;
        s_ba1 <= s_ba1 | byte_address_lsb;
      end
      if (!write_strobe_high_n || !write_strobe_low_n) begin
        wdat <= data_out;
        s_ba <= byte_address_lsb;
      end
    end
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    checked++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic conclude;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : conclude
  // one request, then compare pins and results with the reference
  task automatic op(input logic [1:0] k, input logic [20:0] pa, input logic [7:0] d);
    int n;
    logic bm;
    logic [1:0] st, en;
    logic [15:0] ew;
    @(posedge clock);
    req_valid <= 1'b1;
    req_kind <= k;
    table_address_pointer <= pa;
    table_data_latch <= d;
    {s_wh, s_wl, s_ub, s_lb, s_ale, s_ba0, s_ba1, s_mov} <= 8'h00;
    a0 <= bus_mode == EPM_BUS8_MUX ? {3'h0, pa[17:1]} : pa[20:1];
    act <= 1'b1;
    @(posedge clock);
    req_valid <= 1'b0;
    n = 0;
    // bounded wait for the completion pulse
    while (done !== 1'b1 && n < 40) begin
      @(negedge clock);
      n++;
    end
    if (n >= 40) begin
      fail_count++;
      conclude();
    end
    repeat (2) @(posedge clock);
    act <= 1'b0;
    bm = bus_mode != EPM_BUS16;
    st = 2'b00;
    en = bm ? 2'b00 : 2'b11;
    ew = {d, d};
    if (k == 2'h2) begin
      st = pa[0] ? 2'b10 : 2'b01;
      if (bm) begin
        st = 2'b01;
        ew[15:8] = wdat[15:8];
      end else if (table_write_mode_field[1]) begin
        st = pa[0] ? 2'b10 : 2'b00;
        ew = {d, held};
        held = pa[0] ? held : d;
      end else if (table_write_mode_field[0]) begin
        st = 2'b10;
        en = {pa[0], !pa[0]};
      end
      if (st != 2'b00) begin
        chk("write_data", ew, wdat);
        chk("write_ba", 16'(pa[0]), 16'(s_ba));
      end
    end
    chk("strobes", 16'(st), 16'({s_wh, s_wl}));
    chk("enables", 16'(en), 16'({s_ub, s_lb}));
    chk("port_mode", 16'(bm), 16'(port_mode));
    chk("addr_hold", 16'h0000, 16'(s_mov));
    chk("ale", 16'(bus_mode != EPM_BUS8_DEMUX), 16'(s_ale));
    if (k == 2'h1) begin
      chk("rd_data", 16'(epm_mem_model_inst.mem_byte(pa)), 16'(rd_data));
    end
    if (k == 2'h0) begin
      chk("instr", {epm_mem_model_inst.mem_byte(pa | 21'h1),
        epm_mem_model_inst.mem_byte(pa & ~21'h1)}, instr_word);
      chk("fetch_ba", bm ? 16'h0003 : 16'h0001, 16'({s_ba1, s_ba0}));
    end
  endtask : op
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {sys_rst, clk_en, req_valid, act, req_kind, table_data_latch} <= 14'h3000;
    bus_mode <= EPM_BUS16;
    table_write_mode_field <= 2'h0;
    table_address_pointer <= 21'h0;
    rnd = 32'h1b9e;
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    chk("idle_pins", 16'h0007, 16'({data_oe_n, write_strobe_high_n, write_strobe_low_n}));
    for (int m = 0; m < 3; m++) begin
      for (int w = 0; w < 4; w++) begin
        bus_mode <= epm_bus_mode_type'(m);
        table_write_mode_field <= 2'(w);
        repeat (2) @(posedge clock);
        for (int i = 0; i < 3; i++) begin
          rnd = lfsr(rnd);
          p = m == 2 ? {rnd[20:2], 2'b00} : {3'h0, rnd[17:2], 2'b00};
          op(2'h0, p, 8'h00);
          op(2'h1, p, 8'h00);
          op(2'h1, p + 21'h1, 8'h00);
          op(2'h1, p + (m == 0 ? 21'h2 : 21'h1), 8'h00);
          op(2'h2, p, rnd[7:0]);
          op(2'h2, p + 21'h1, rnd[15:8]);
          op(2'h2, p, rnd[23:16]);
          op(2'h2, p, rnd[31:24]);
          op(2'h2, p + 21'h1, ~rnd[7:0]);
          op(2'h2, p + 21'h1, ~rnd[15:8]);
        end
        $display("test mode %0d field %0d ended", m, w);
      end
    end
    conclude();
  end
endmodule : epm_bus_tb
